// ===== tpb_fifo.sv
`timescale 1ns/1ps
module tpb_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wrPtr;
		logic [AW-1:0]               rdPtr;
		logic [AW:0]                 count;
	} fifo_state_s;

	fifo_state_s st;
	fifo_state_s next_st;
	logic        push;
	logic        pop;

	////////////////////////////////////////////////////////////////////////
	// Honest full and empty
	assign inReady  = (st.count != (AW+1)'(DEPTH));
	assign outValid = (st.count != '0);
	assign outData  = st.mem[st.rdPtr];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// Pointer and count update
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wrPtr] = inData;
			next_st.wrPtr = (st.wrPtr == AW'(DEPTH-1)) ? '0 : st.wrPtr + 1'b1;
		end
		if (pop) begin
			next_st.rdPtr = (st.rdPtr == AW'(DEPTH-1)) ? '0 : st.rdPtr + 1'b1;
		end
		if (push && !pop) begin
			next_st.count = st.count + 1'b1;
		end else if (pop && !push) begin
			next_st.count = st.count - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule // tpb_fifo

// ===== tpb_pkg.sv
package tpb_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register offsets on the register port
	localparam logic [8:0] ADDR_RSVD_A  = 9'h082;
	localparam logic [8:0] ADDR_FAULT0  = 9'h088;
	localparam logic [8:0] ADDR_FAULT1  = 9'h089;
	localparam logic [8:0] ADDR_FAULT2  = 9'h08a;
	localparam logic [8:0] ADDR_FAULT3  = 9'h08b;
	localparam logic [8:0] ADDR_RSVD_B  = 9'h08c;
	localparam logic [8:0] ADDR_RSVD_C  = 9'h08d;
	localparam logic [8:0] ADDR_PATCTRL = 9'h090;
	localparam logic [8:0] ADDR_RSVD_D  = 9'h091;
	localparam logic [8:0] ADDR_PATLOW  = 9'h092;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] RST_RSVD_A  = 16'h000f;
	localparam logic [15:0] RST_FAULT   = 16'h0000;
	localparam logic [15:0] RST_RSVD_B  = 16'h0000;
	localparam logic [15:0] RST_RSVD_C  = 16'hffff;
	localparam logic [3:0]  RST_PATCTRL = 4'h0;
	localparam logic [15:0] RST_RSVD_D  = 16'h0000;
	localparam logic [15:0] RST_PATLOW  = 16'h0100;

	////////////////////////////////////////////////////////////////////////
	// Field positions of the pattern control word
	localparam int BIT_PAT_EN    = 0;
	localparam int BIT_PAT_INC   = 1;
	localparam int BIT_PRBS_EN   = 2;
	localparam int BIT_FRAMED    = 3;
	localparam int PATCTRL_W     = 4;
	// Lane 0 low byte and high bits fields
	localparam int LANE0_LOW_LSB = 0;
	localparam int LANE0_LOW_W   = 8;
	localparam int LANE0_HIGH_W  = 2;

	////////////////////////////////////////////////////////////////////////
	// Fault flag layout and data path sizes
	localparam int FAULT_WORDS   = 4;
	localparam int WORD_W        = 16;
	localparam int PIX_W         = 10;
	localparam int PRBS_W        = 15;
	localparam logic [14:0] PRBS_SEED = 15'h7fff;
	localparam int FIFO_DEPTH    = 4;

	////////////////////////////////////////////////////////////////////////
	// Output word source, one-hot
	typedef enum logic [3:0] {
		MODE_PASS  = 4'b0001,
		MODE_CONST = 4'b0010,
		MODE_INC   = 4'b0100,
		MODE_PRBS  = 4'b1000
	} tpb_mode_e;

	// One data path word with its sync marker
	typedef struct packed {
		logic             isSync;
		logic [PIX_W-1:0] data;
	} tpb_word_s;

	// Register port request
	typedef struct packed {
		logic        write;
		logic        read;
		logic [8:0]  addr;
		logic [15:0] wdata;
	} tpb_req_s;

endpackage

// ===== tpb_status_pattern.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module tpb_status_pattern
	import tpb_pkg::*;
#(
	parameter int NUM_CH = 64
) (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire tpb_req_s                regReq,
	output logic      [WORD_W-1:0]       regRdata,
	output logic                         regRvalid,
	input  wire logic [NUM_CH-1:0]       calShortfall,
	input  wire logic [LANE0_HIGH_W-1:0] lane0PatternHigh,
	input  wire tpb_word_s               pixIn,
	input  wire logic                    pixInValid,
	output logic                         pixInReady,
	output tpb_word_s                    pixOut,
	output logic                         pixOutValid,
	input  wire logic                    pixOutReady,
	output logic      [PATCTRL_W-1:0]    patternControl
);

	////////////////////////////////////////////////////////////////////////
	// Block state
	typedef struct packed {
		logic [NUM_CH-1:0]    fault;
		logic [WORD_W-1:0]    rsvdA;
		logic [WORD_W-1:0]    rsvdB;
		logic [WORD_W-1:0]    rsvdC;
		logic [WORD_W-1:0]    rsvdD;
		logic [PATCTRL_W-1:0] ctrl;
		logic [WORD_W-1:0]    patLow;
		logic [WORD_W-1:0]    rdData;
		logic                 rdValid;
		logic [PIX_W-1:0]     incValue;
		logic [PRBS_W-1:0]    prbs;
	} tpb_state_s;

	tpb_state_s       st;
	tpb_state_s       next_st;
	tpb_mode_e        mode;
	logic [PIX_W-1:0] constWord;
	logic [PIX_W-1:0] patWord;
	logic             advance;
	logic             prbsBit;
	tpb_word_s        fifoInWord;
	logic             fifoInValid;
	logic             fifoInReady;
	logic [PIX_W:0]   fifoOutBits;
	logic [3:0]       faultHit;

	////////////////////////////////////////////////////////////////////////
	// Register outputs
	assign regRdata       = st.rdData;
	assign regRvalid      = st.rdValid;
	assign patternControl = st.ctrl;

	// Which fault word the current read targets
	always_comb begin
		faultHit[0] = regReq.read && (regReq.addr == ADDR_FAULT0);
		faultHit[1] = regReq.read && (regReq.addr == ADDR_FAULT1);
		faultHit[2] = regReq.read && (regReq.addr == ADDR_FAULT2);
		faultHit[3] = regReq.read && (regReq.addr == ADDR_FAULT3);
	end

	////////////////////////////////////////////////////////////////////////
	// Source selection for the output words
	always_comb begin
		if (st.ctrl[BIT_PRBS_EN]) begin
			mode = MODE_PRBS;
		end else if (st.ctrl[BIT_PAT_EN]) begin
			if (st.ctrl[BIT_PAT_INC]) begin
				mode = MODE_INC;
			end else begin
				mode = MODE_CONST;
			end
		end else begin
			mode = MODE_PASS;
		end
	end

	// Lane 0 constant built from low byte and high field
	assign constWord = {lane0PatternHigh,
		st.patLow[LANE0_LOW_LSB +: LANE0_LOW_W]};

	// Pattern word for the current mode
	always_comb begin
		case (mode)
			MODE_PRBS: begin
				patWord = st.prbs[PIX_W-1:0];
			end
			MODE_INC: begin
				patWord = st.incValue;
			end
			MODE_CONST: begin
				patWord = constWord;
			end
			default: begin
				patWord = constWord;
			end
		endcase
	end

	// PRBS feedback, x^15 + x^14 + 1
	assign prbsBit = st.prbs[PRBS_W-1] ^ st.prbs[PRBS_W-2];

	////////////////////////////////////////////////////////////////////////
	// Data path steering into the FIFO
	always_comb begin
		fifoInWord  = pixIn;
		fifoInValid = pixInValid;
		pixInReady  = fifoInReady;
		advance     = 1'b0;
		case (mode)
			MODE_PASS: begin
				fifoInWord  = pixIn;
				fifoInValid = pixInValid;
				pixInReady  = fifoInReady;
			end
			MODE_CONST, MODE_INC, MODE_PRBS: begin
				if (st.ctrl[BIT_FRAMED]) begin
					// Framed: syncs pass, pixel words replaced
					fifoInValid = pixInValid;
					pixInReady  = fifoInReady;
					fifoInWord.isSync = pixIn.isSync;
					fifoInWord.data   = pixIn.isSync ? pixIn.data
						: patWord;
					advance = pixInValid && fifoInReady && !pixIn.isSync;
				end else begin
					// Unframed: free-running pattern, source drained
					fifoInValid       = 1'b1;
					pixInReady        = 1'b1;
					fifoInWord.isSync = 1'b0;
					fifoInWord.data   = patWord;
					advance           = fifoInReady;
				end
			end
			default: begin
				fifoInWord  = pixIn;
				fifoInValid = pixInValid;
				pixInReady  = fifoInReady;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: registers, flags and generators
	always_comb begin
		next_st = st;
		next_st.rdValid = regReq.read;

		// Writes to the writable words
		if (regReq.write) begin
			case (regReq.addr)
				ADDR_RSVD_A: begin
					next_st.rsvdA = regReq.wdata;
				end
				ADDR_RSVD_B: begin
					next_st.rsvdB = regReq.wdata;
				end
				ADDR_RSVD_C: begin
					next_st.rsvdC = regReq.wdata;
				end
				ADDR_PATCTRL: begin
					next_st.ctrl = regReq.wdata[PATCTRL_W-1:0];
				end
				ADDR_RSVD_D: begin
					next_st.rsvdD = regReq.wdata;
				end
				ADDR_PATLOW: begin
					next_st.patLow = regReq.wdata;
				end
				default: begin
					next_st.ctrl = st.ctrl;
				end
			endcase
		end

		// Read data mux, unmapped reads give zero
		if (regReq.read) begin
			case (regReq.addr)
				ADDR_RSVD_A: begin
					next_st.rdData = st.rsvdA;
				end
				ADDR_FAULT0: begin
					next_st.rdData = st.fault[0*WORD_W +: WORD_W];
				end
				ADDR_FAULT1: begin
					next_st.rdData = st.fault[1*WORD_W +: WORD_W];
				end
				ADDR_FAULT2: begin
					next_st.rdData = st.fault[2*WORD_W +: WORD_W];
				end
				ADDR_FAULT3: begin
					next_st.rdData = st.fault[3*WORD_W +: WORD_W];
				end
				ADDR_RSVD_B: begin
					next_st.rdData = st.rsvdB;
				end
				ADDR_RSVD_C: begin
					next_st.rdData = st.rsvdC;
				end
				ADDR_PATCTRL: begin
					next_st.rdData = {{(WORD_W-PATCTRL_W){1'b0}}, st.ctrl};
				end
				ADDR_RSVD_D: begin
					next_st.rdData = st.rsvdD;
				end
				ADDR_PATLOW: begin
					next_st.rdData = st.patLow;
				end
				default: begin
					next_st.rdData = '0;
				end
			endcase
		end

		// Fault flags: read clears word, new shortfall wins
		for (int w = 0; w < FAULT_WORDS; w++) begin
			if (faultHit[w]) begin
				next_st.fault[w*WORD_W +: WORD_W] = '0;
			end
		end
		next_st.fault = next_st.fault | calShortfall;

		// Incrementing value reloads from the constant while not in incrementing mode
		if (mode != MODE_INC) begin
			next_st.incValue = constWord;
		end else if (advance) begin
			next_st.incValue = st.incValue + 1'b1;
		end

		// PRBS restarts from seed while disabled
		if (mode != MODE_PRBS) begin
			next_st.prbs = PRBS_SEED;
		end else if (advance) begin
			next_st.prbs = {st.prbs[PRBS_W-2:0], prbsBit};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register with documented reset values
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st.fault    <= {FAULT_WORDS{RST_FAULT}};
			st.rsvdA    <= RST_RSVD_A;
			st.rsvdB    <= RST_RSVD_B;
			st.rsvdC    <= RST_RSVD_C;
			st.rsvdD    <= RST_RSVD_D;
			st.ctrl     <= RST_PATCTRL;
			st.patLow   <= RST_PATLOW;
			st.rdData   <= '0;
			st.rdValid  <= 1'b0;
			st.incValue <= '0;
			st.prbs     <= PRBS_SEED;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output buffer, four words
	tpb_fifo #(
		.WIDTH (PIX_W + 1),
		.DEPTH (FIFO_DEPTH)
	) uFifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inData   (fifoInWord),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.outData  (fifoOutBits),
		.outValid (pixOutValid),
		.outReady (pixOutReady)
	);

	// Unpack buffer output
	assign pixOut = tpb_word_s'(fifoOutBits);

endmodule // tpb_status_pattern

// ===== tpb_status_pattern_assertions.sv
`timescale 1ns/1ps
module tpb_status_pattern_assertions
	import tpb_pkg::*;
#(
	parameter int NUM_CH = 64
) (
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire tpb_req_s                regReq,
	input wire logic [WORD_W-1:0]       regRdata,
	input wire logic                    regRvalid,
	input wire logic [NUM_CH-1:0]       calShortfall,
	input wire logic [LANE0_HIGH_W-1:0] lane0PatternHigh,
	input wire tpb_word_s               pixIn,
	input wire logic                    pixInValid,
	input wire logic                    pixInReady,
	input wire tpb_word_s               pixOut,
	input wire logic                    pixOutValid,
	input wire logic                    pixOutReady,
	input wire logic [PATCTRL_W-1:0]    patternControl
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Control word write strobe
	wire logic ctlW = regReq.write && regReq.addr == ADDR_PATCTRL;

	// Shortfall on a channel, then a read of its word
	sequence flagThenRead(ch, a);
		calShortfall[ch] ##1 regReq.read && regReq.addr == a;
	endsequence
	sequence cleanRead;
		regReq.read && regReq.addr == ADDR_FAULT0 && calShortfall[15:0] == 16'h0;
	endsequence

	chk_rvalid_pulse: assert property (regReq.read |=> regRvalid)
		else $error("read answer missing");
	chk_rvalid_quiet: assert property (!regReq.read |=> !regRvalid)
		else $error("spurious read answer");
	chk_rdata_hold: assert property (!regReq.read |=> $stable(regRdata))
		else $error("read data moved");
	chk_ctrl_write: assert property (ctlW |=>
		patternControl == PATCTRL_W'($past(regReq.wdata)))
		else $error("control write lost");
	chk_ctrl_hold: assert property (!ctlW |=> $stable(patternControl))
		else $error("control changed unasked");
	chk_fault_set: assert property (flagThenRead(0, ADDR_FAULT0) |=> regRdata[0])
		else $error("fault flag not set");
	chk_fault_top: assert property (
		flagThenRead(NUM_CH-1, ADDR_FAULT3) |=> regRdata[15])
		else $error("top channel flag misplaced");
	chk_fault_clear: assert property (cleanRead ##1
		regReq.read && regReq.addr == ADDR_FAULT0 |=> regRdata == 16'h0)
		else $error("fault word not cleared");
	chk_pass_word: assert property (patternControl == 4'h0 && pixInValid
		&& pixInReady && !pixOutValid |=> pixOutValid && pixOut == $past(pixIn))
		else $error("pass word wrong");
	chk_out_hold: assert property (pixOutValid && !pixOutReady |=>
		pixOutValid && $stable(pixOut))
		else $error("output word dropped");
	chk_free_ready: assert property ((patternControl[0] || patternControl[2])
		&& !patternControl[3] |-> pixInReady)
		else $error("unframed input stalled");
endmodule // tpb_status_pattern_assertions

bind tpb_status_pattern tpb_status_pattern_assertions #(
	.NUM_CH (NUM_CH)
) chk_u (
	.clk              (clk),
	.rst_n            (rst_n),
	.regReq           (regReq),
	.regRdata         (regRdata),
	.regRvalid        (regRvalid),
	.calShortfall     (calShortfall),
	.lane0PatternHigh (lane0PatternHigh),
	.pixIn            (pixIn),
	.pixInValid       (pixInValid),
	.pixInReady       (pixInReady),
	.pixOut           (pixOut),
	.pixOutValid      (pixOutValid),
	.pixOutReady      (pixOutReady),
	.patternControl   (patternControl)
);

// ===== tpb_status_pattern_test.sv
`timescale 1ns/1ps
module tpb_status_pattern_test
	import tpb_pkg::*;
;
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	tpb_req_s        regReq = '0;
	logic [15:0]     regRdata;
	logic            regRvalid, pixInReady, pixOutValid;
	logic [63:0]     calShortfall = '0;
	logic [1:0]      lane0PatternHigh = '0;
	tpb_word_s       pixIn = '0, pixOut;
	logic            pixInValid = 1'b0, pixOutReady = 1'b0;
	logic [3:0]      patternControl, ctrl = '0;
	int              fail_count = 0, checked = 0, cyc = 0, pat, lfsr;
	bit              unf, hold;
	tpb_word_s       q[$];
	logic [15:0]     w;
	logic [63:0]     f;
	logic [8:0]      ad[11] = '{ADDR_RSVD_A, ADDR_FAULT0, ADDR_FAULT1,
		ADDR_FAULT2, ADDR_FAULT3, ADDR_RSVD_B, ADDR_RSVD_C, ADDR_PATCTRL,
		ADDR_RSVD_D, 9'h0a0, ADDR_PATLOW};
	logic [15:0]     rv[11] = '{RST_RSVD_A, RST_FAULT, RST_FAULT, RST_FAULT,
		RST_FAULT, RST_RSVD_B, RST_RSVD_C, 16'h0000, RST_RSVD_D, 16'h0000,
		RST_PATLOW};
	logic [3:0]      md[7] = '{4'h1, 4'h3, 4'h4, 4'h7, 4'h9, 4'hb, 4'hc};

	tpb_status_pattern dut_u (
		.clk              (clk),
		.rst_n            (rst_n),
		.regReq           (regReq),
		.regRdata         (regRdata),
		.regRvalid        (regRvalid),
		.calShortfall     (calShortfall),
		.lane0PatternHigh (lane0PatternHigh),
		.pixIn            (pixIn),
		.pixInValid       (pixInValid),
		.pixInReady       (pixInReady),
		.pixOut           (pixOut),
		.pixOutValid      (pixOutValid),
		.pixOutReady      (pixOutReady),
		.patternControl   (patternControl)
	);

	// Clock and hang guard
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare and verdict
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic summarize();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Register port cycles
	task automatic wr(logic [8:0] a, logic [15:0] d);
		regReq = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		regReq.write = 1'b0;
		// Idle edge so the next request never reuses this time step
		@(negedge clk);
	endtask
	task automatic rd(logic [8:0] a, logic [15:0] e);
		regReq = '{1'b0, 1'b1, a, 16'h0};
		@(negedge clk);
		regReq.read = 1'b0;
		chk("rvalid", regRvalid, 1);
		chk("rdata", regRdata, e);
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Pattern model and one stream cycle
	function automatic logic [9:0] gen();
		logic [9:0] v;
		if (ctrl[2]) begin
			v = lfsr[9:0];
			lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
		end else begin
			v = pat[9:0];
			if (ctrl[1])
				pat++;
		end
		return v;
	endfunction
	task automatic step(logic v, logic r, bit run);
		tpb_word_s x;
		// A refused word stands until the block takes it
		if (!hold) begin
			pixIn.isSync = ctrl[3] && ($urandom % 4 == 0);
			pixIn.data   = 10'($urandom);
			pixInValid   = v;
		end
		pixOutReady = r;
		#1;
		if (run)
			chk("inready", pixInReady, unf || q.size() < FIFO_DEPTH);
		if (pixInValid && pixInReady && !unf) begin
			x = pixIn;
			if ((ctrl[0] || ctrl[2]) && !x.isSync)
				x.data = gen();
			q.push_back(x);
		end
		if (pixOutValid && pixOutReady) begin
			if (unf)
				x = '{1'b0, gen()};
			else
				x = q.pop_front();
			chk("pixout", pixOut, x);
		end
		hold = pixInValid && !pixInReady;
		@(negedge clk);
	endtask
	task automatic run_mode(logic [3:0] c, logic [9:0] k, int n);
		pixInValid = 1'b0;
		pixOutReady = 1'b0;
		ctrl = c;
		unf = (c[0] || c[2]) && !c[3];
		pat = k;
		lfsr = PRBS_SEED;
		lane0PatternHigh = k[9:8];
		wr(ADDR_PATLOW, {8'h5a, k[7:0]});
		wr(ADDR_PATCTRL, {12'hfff, c});
		rd(ADDR_PATCTRL, {12'h000, c});
		chk("patctrl", patternControl, c);
		repeat (n) step(1'($urandom), 1'($urandom), 1);
		// Let a refused word be taken before the source goes idle
		repeat (2) step(1'b0, 1'b1, 1);
		pixInValid = 1'b0;
		pixOutReady = 1'b0;
		wr(ADDR_PATCTRL, 16'h0000);
		repeat (8) step(1'b0, 1'b1, 0);
		chk("drained", pixOutValid, 0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'h09a302ee));
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		foreach (ad[i]) rd(ad[i], rv[i]);
		foreach (ad[i]) begin
			w = 16'($urandom);
			if (i == 7)
				w[3:0] = 4'h0;
			wr(ad[i], w);
			rd(ad[i], (i inside {[1:4], 9}) ? rv[i] : i == 7 ? 16'h0 : w);
		end
		// Sticky flags, then clear on read
		f = {$urandom, $urandom};
		f[0] = 1'b1;
		f[63] = 1'b1;
		calShortfall = f;
		@(negedge clk);
		calShortfall = '0;
		for (int i = 3; i >= 0; i--)
			rd(9'(ADDR_FAULT0 + i), f[16*i +: 16]);
		calShortfall[0] = 1'b1;
		@(negedge clk);
		calShortfall = '0;
		regReq = '{1'b0, 1'b1, ADDR_FAULT0, 16'h0};
		@(negedge clk);
		chk("fault0", regRdata, 16'h0001);
		@(negedge clk);
		regReq.read = 1'b0;
		chk("fault0clr", regRdata, 16'h0000);
		@(negedge clk);
		// Pass mode, fill to refusal, then every pattern mode
		run_mode(4'h0, 10'h000, 60);
		repeat (6) step(1'b1, 1'b0, 1);
		repeat (6) step(1'b0, 1'b1, 1);
		run_mode(4'h3, 10'h3fc, 40);
		foreach (md[i]) run_mode(md[i], 10'($urandom), 80);
		summarize();
	end
endmodule // tpb_status_pattern_test
